// ---- tmw_pkg.sv ----
`default_nettype none
package tmw_pkg;

    // ----------------------------------------------------------------
    // Counter limits
    // ----------------------------------------------------------------
    localparam logic [7:0] TMW_MAX       = 8'hFF;
    localparam logic [7:0] TMW_BOTTOM    = 8'h00;
    localparam logic [7:0] TMW_ONE       = 8'h01;
    localparam logic [7:0] TMW_COUNT_RST = 8'h00;
    localparam logic [7:0] TMW_CMP_RST   = 8'h00;

    // ----------------------------------------------------------------
    // Waveform mode codes
    // ----------------------------------------------------------------
    localparam logic [2:0] TMW_MODE_NORMAL  = 3'h0;
    localparam logic [2:0] TMW_MODE_PC_MAX  = 3'h1;
    localparam logic [2:0] TMW_MODE_CTC     = 3'h2;
    localparam logic [2:0] TMW_MODE_FAST    = 3'h3;
    localparam logic [2:0] TMW_MODE_PC_CMPA = 3'h5;
    localparam logic [2:0] TMW_MODE_FAST_A  = 3'h7;

    // ----------------------------------------------------------------
    // Output action codes
    // ----------------------------------------------------------------
    localparam logic [1:0] TMW_ACT_NONE   = 2'h0;
    localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TMW_ACT_CLEAR  = 2'h2;
    localparam logic [1:0] TMW_ACT_SET    = 2'h3;

    // ----------------------------------------------------------------
    // Prescaler: clock select code to divide-by-minus-one mask
    // ----------------------------------------------------------------
    localparam int         TMW_PRE_W      = 10;
    localparam logic [2:0] TMW_CS_STOP    = 3'h0;
    localparam logic [9:0] TMW_MASK_1     = 10'h000;
    localparam logic [9:0] TMW_MASK_8     = 10'h007;
    localparam logic [9:0] TMW_MASK_32    = 10'h01F;
    localparam logic [9:0] TMW_MASK_64    = 10'h03F;
    localparam logic [9:0] TMW_MASK_128   = 10'h07F;
    localparam logic [9:0] TMW_MASK_256   = 10'h0FF;
    localparam logic [9:0] TMW_MASK_1024  = 10'h3FF;

    // Counting class decoded from the mode field
    typedef enum logic [1:0] {
        TMW_CLS_NORMAL = 2'b00,
        TMW_CLS_CTC    = 2'b01,
        TMW_CLS_FAST   = 2'b10,
        TMW_CLS_PHASE  = 2'b11
    } tmw_class_t;

    // Per-channel software controls
    typedef struct packed {
        logic [1:0] outputActionSelect;
        logic       forceCompareStrobe;
        logic       compareWrite;
        logic [7:0] compareData;
        logic       flagClear;
        logic       pinDirOut;
        logic       portData;
    } tmw_chan_cfg_t;

    // Per-channel status
    typedef struct packed {
        logic       compareFlag;
        logic       compareOutput;
        logic       pinOut;
        logic       pinOeN;
        logic [7:0] compareActive;
    } tmw_chan_stat_t;

endpackage
`default_nettype wire

// ---- tmw_timer8_waveform.sv ----
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------------
// One compare channel: buffer, match, flag and waveform output
// --------------------------------------------------------------------
module tmw_compare_channel
    import tmw_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire tmw_class_t    countClass,
    input  wire logic [7:0]    countValue,
    input  wire logic [7:0]    topValue,
    input  wire logic          countDown,
    input  wire logic          matchBlocked,
    input  wire tmw_chan_cfg_t cfg,
    output tmw_chan_stat_t     stat
);

    logic [7:0] bufferReg;
    logic [7:0] activeReg;
    logic       flagReg;
    logic       outReg;
    logic       pinReg;
    logic       pwmMode;
    logic       match;
    logic       atTop;
    logic       reload;
    logic       outNext;

    assign pwmMode = (countClass == TMW_CLS_FAST) || (countClass == TMW_CLS_PHASE);
    assign atTop   = (countValue == topValue);
    assign match   = tick && !matchBlocked && (countValue == activeReg);

    // Fast reloads as the count wraps to bottom, phase at the top turn
    assign reload = tick && atTop && pwmMode;

    // ----------------------------------------------------------------
    // Compare value storage
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bufferReg <= TMW_CMP_RST;
        end else if (cfg.compareWrite) begin
            bufferReg <= cfg.compareData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            activeReg <= TMW_CMP_RST;
        end else if (!pwmMode && cfg.compareWrite) begin
            activeReg <= cfg.compareData;
        end else if (!pwmMode) begin
            activeReg <= bufferReg;
        end else if (reload) begin
            activeReg <= bufferReg;
        end
    end

    // ----------------------------------------------------------------
    // Compare flag; a new match wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flagReg <= 1'b0;
        end else if (match) begin
            flagReg <= 1'b1;
        end else if (cfg.flagClear) begin
            flagReg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Waveform generator
    // ----------------------------------------------------------------
    always_comb begin
        outNext = outReg;
        unique case (countClass)
            TMW_CLS_NORMAL, TMW_CLS_CTC: begin
                // Force acts like a match but never touches the flag
                if (match || cfg.forceCompareStrobe) begin
                    unique case (cfg.outputActionSelect)
                        TMW_ACT_NONE:   outNext = outReg;
                        TMW_ACT_TOGGLE: outNext = !outReg;
                        TMW_ACT_CLEAR:  outNext = 1'b0;
                        TMW_ACT_SET:    outNext = 1'b1;
                    endcase
                end
            end
            TMW_CLS_FAST: begin
                unique case (cfg.outputActionSelect)
                    TMW_ACT_NONE: outNext = outReg;
                    TMW_ACT_TOGGLE: begin
                        if (match) begin
                            outNext = !outReg;
                        end
                    end
                    TMW_ACT_CLEAR, TMW_ACT_SET: begin
                        // Bottom wins at top so compare MAX gives a steady level
                        if (tick && atTop) begin
                            outNext = (cfg.outputActionSelect == TMW_ACT_CLEAR);
                        end else if (match) begin
                            outNext = (cfg.outputActionSelect == TMW_ACT_SET);
                        end
                    end
                endcase
            end
            TMW_CLS_PHASE: begin
                unique case (cfg.outputActionSelect)
                    TMW_ACT_NONE: outNext = outReg;
                    TMW_ACT_TOGGLE: begin
                        if (match) begin
                            outNext = !outReg;
                        end
                    end
                    TMW_ACT_CLEAR, TMW_ACT_SET: begin
                        // Match at top counts as downcount, at bottom as upcount
                        if (match) begin
                            if (atTop || (countDown && countValue != TMW_BOTTOM)) begin
                                outNext = (cfg.outputActionSelect == TMW_ACT_CLEAR);
                            end else begin
                                outNext = (cfg.outputActionSelect == TMW_ACT_SET);
                            end
                        end
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            outReg <= 1'b0;
        end else begin
            outReg <= outNext;
        end
    end

    // ----------------------------------------------------------------
    // Port override
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinReg <= 1'b0;
        end else if (cfg.outputActionSelect != TMW_ACT_NONE) begin
            pinReg <= outNext;
        end else begin
            pinReg <= cfg.portData;
        end
    end

    assign stat.compareFlag   = flagReg;
    assign stat.compareOutput = outReg;
    assign stat.pinOut        = pinReg;
    assign stat.pinOeN        = !cfg.pinDirOut;
    assign stat.compareActive = activeReg;

endmodule // tmw_compare_channel

// --------------------------------------------------------------------
// Timer top: prescaler, counter unit and two compare channels
// --------------------------------------------------------------------
module tmw_timer8_waveform
    import tmw_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic [2:0]    clockSelect,
    input  wire logic [2:0]    waveformModeSelect,
    input  wire logic          countWrite,
    input  wire logic [7:0]    countWriteData,
    input  wire logic          overflowFlagClear,
    input  wire tmw_chan_cfg_t chanCfgA,
    input  wire tmw_chan_cfg_t chanCfgB,
    output logic [7:0]         countValue,
    output logic               overflowFlag,
    output logic               timerTick,
    output tmw_chan_stat_t     chanStatA,
    output tmw_chan_stat_t     chanStatB
);

    logic [TMW_PRE_W-1:0] prescaleReg;
    logic [TMW_PRE_W-1:0] prescaleMask;
    logic                 tick;
    tmw_class_t           countClass;
    logic [7:0]           topValue;
    logic [7:0]           countReg;
    logic [7:0]           countNext;
    logic                 countDownReg;
    logic                 countDownNext;
    logic                 overflowReg;
    logic                 overflowSet;
    logic                 blockReg;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    always_comb begin
        prescaleMask = TMW_MASK_1;
        unique case (clockSelect)
            3'h0: prescaleMask = TMW_MASK_1;
            3'h1: prescaleMask = TMW_MASK_1;
            3'h2: prescaleMask = TMW_MASK_8;
            3'h3: prescaleMask = TMW_MASK_32;
            3'h4: prescaleMask = TMW_MASK_64;
            3'h5: prescaleMask = TMW_MASK_128;
            3'h6: prescaleMask = TMW_MASK_256;
            3'h7: prescaleMask = TMW_MASK_1024;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prescaleReg <= '0;
        end else begin
            prescaleReg <= prescaleReg + 10'h001;
        end
    end

    // Free-running divider, so the first tick after a select may be early
    assign tick = (clockSelect != TMW_CS_STOP) && ((prescaleReg & prescaleMask) == prescaleMask);

    // ----------------------------------------------------------------
    // Mode decode; actions play no part here
    // ----------------------------------------------------------------
    always_comb begin
        countClass = TMW_CLS_NORMAL;
        topValue   = TMW_MAX;
        unique case (waveformModeSelect)
            TMW_MODE_NORMAL: countClass = TMW_CLS_NORMAL;
            TMW_MODE_CTC: begin
                countClass = TMW_CLS_CTC;
                topValue   = chanStatA.compareActive;
            end
            TMW_MODE_FAST: countClass = TMW_CLS_FAST;
            TMW_MODE_FAST_A: begin
                countClass = TMW_CLS_FAST;
                topValue   = chanStatA.compareActive;
            end
            TMW_MODE_PC_MAX: countClass = TMW_CLS_PHASE;
            TMW_MODE_PC_CMPA: begin
                countClass = TMW_CLS_PHASE;
                topValue   = chanStatA.compareActive;
            end
            default: countClass = TMW_CLS_NORMAL;
        endcase
    end

    // ----------------------------------------------------------------
    // Counter unit
    // ----------------------------------------------------------------
    always_comb begin
        countNext     = countReg;
        countDownNext = countDownReg;
        overflowSet   = 1'b0;
        if (tick) begin
            unique case (countClass)
                TMW_CLS_NORMAL: begin
                    countNext   = countReg + TMW_ONE;
                    overflowSet = (countReg == TMW_MAX);
                end
                TMW_CLS_CTC: begin
                    // A top below the count misses and wraps through MAX; a blocked match skips the clear
                    if (countReg == topValue && !blockReg) begin
                        countNext = TMW_BOTTOM;
                    end else begin
                        countNext = countReg + TMW_ONE;
                    end
                    overflowSet = (countReg == TMW_MAX);
                end
                TMW_CLS_FAST: begin
                    if (countReg == topValue) begin
                        countNext   = TMW_BOTTOM;
                        overflowSet = 1'b1;
                    end else begin
                        countNext = countReg + TMW_ONE;
                    end
                end
                TMW_CLS_PHASE: begin
                    if (!countDownReg && countReg == topValue) begin
                        countNext     = countReg - TMW_ONE;
                        countDownNext = 1'b1;
                    end else if (countDownReg && countReg == TMW_BOTTOM) begin
                        countNext     = countReg + TMW_ONE;
                        countDownNext = 1'b0;
                    end else if (countDownReg) begin
                        countNext   = countReg - TMW_ONE;
                        overflowSet = (countReg == TMW_ONE);
                    end else begin
                        countNext = countReg + TMW_ONE;
                    end
                end
            endcase
        end
        if (countClass != TMW_CLS_PHASE) begin
            countDownNext = 1'b0;
        end
    end

    // Software write overrides any count or clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            countReg <= TMW_COUNT_RST;
        end else if (countWrite) begin
            countReg <= countWriteData;
        end else begin
            countReg <= countNext;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            countDownReg <= 1'b0;
        end else begin
            countDownReg <= countDownNext;
        end
    end

    // ----------------------------------------------------------------
    // Match blocking after a count write, held across a stopped clock
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            blockReg <= 1'b0;
        end else if (countWrite) begin
            blockReg <= 1'b1;
        end else if (tick) begin
            blockReg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Overflow flag; set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflowReg <= 1'b0;
        end else if (overflowSet) begin
            overflowReg <= 1'b1;
        end else if (overflowFlagClear) begin
            overflowReg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Compare channels
    // ----------------------------------------------------------------
    tmw_compare_channel u_chan_a (
        .core_clk     (core_clk),
        .rst          (rst),
        .tick         (tick),
        .countClass   (countClass),
        .countValue   (countReg),
        .topValue     (topValue),
        .countDown    (countDownReg),
        .matchBlocked (blockReg),
        .cfg          (chanCfgA),
        .stat         (chanStatA)
    );

    tmw_compare_channel u_chan_b (
        .core_clk     (core_clk),
        .rst          (rst),
        .tick         (tick),
        .countClass   (countClass),
        .countValue   (countReg),
        .topValue     (topValue),
        .countDown    (countDownReg),
        .matchBlocked (blockReg),
        .cfg          (chanCfgB),
        .stat         (chanStatB)
    );

    assign countValue   = countReg;
    assign overflowFlag = overflowReg;
    assign timerTick    = tick;

endmodule // tmw_timer8_waveform
`default_nettype wire

// ---- tmw_pin_load.sv ----
`timescale 1ns/1ns
`default_nettype none

module tmw_pin_load (
    input  wire logic pinOut,
    input  wire logic pinOeN,
    output wire logic pinLevel
);
    // Released pin floats up through the external pull-up
    assign pinLevel = pinOeN ? 1'b1 : pinOut;
endmodule // tmw_pin_load

`default_nettype wire

// ---- tmw_timer8_waveform_checker.sv ----
`timescale 1ns/1ns
`default_nettype none

module tmw_timer8_waveform_checker
    import tmw_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           rst,
    input wire logic [2:0]     clockSelect,
    input wire logic [2:0]     waveformModeSelect,
    input wire logic           countWrite,
    input wire logic           overflowFlagClear,
    input wire tmw_chan_cfg_t  chanCfgA,
    input wire logic [7:0]     countValue,
    input wire logic           overflowFlag,
    input wire logic           timerTick,
    input wire tmw_chan_stat_t chanStatA
);
    // ----------------------------
    // Match blocking tracker
    // ----------------------------
    logic writeSeen_reg;
    logic plainTick;
    logic matchA;

    // Held until the first tick after a count write, even while stopped
    always_ff @(posedge core_clk) begin
        if (rst) writeSeen_reg <= 1'b0;
        else if (countWrite) writeSeen_reg <= 1'b1;
        else if (timerTick) writeSeen_reg <= 1'b0;
    end
    assign plainTick = timerTick && !countWrite;
    assign matchA    = plainTick && !writeSeen_reg && countValue == chanStatA.compareActive;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_normal_step: assert property ((waveformModeSelect == TMW_MODE_NORMAL && plainTick)
        |=> countValue == $past(countValue) + 8'h01) else $error("normal mode count did not step by one");
    a_normal_wrap: assert property ((waveformModeSelect == TMW_MODE_NORMAL && plainTick && countValue == TMW_MAX)
        |=> overflowFlag && countValue == TMW_BOTTOM) else $error("normal wrap without overflow");
    a_ctc_clear: assert property ((waveformModeSelect == TMW_MODE_CTC && matchA)
        |=> countValue == TMW_BOTTOM) else $error("clear-on-match count not cleared");
    a_fast_wrap: assert property ((waveformModeSelect == TMW_MODE_FAST && plainTick && countValue == TMW_MAX)
        |=> countValue == TMW_BOTTOM && overflowFlag) else $error("fast PWM top handling wrong");
    a_phase_turn: assert property ((waveformModeSelect == TMW_MODE_PC_MAX && plainTick && countValue == TMW_MAX)
        |=> countValue == 8'hFE) else $error("phase PWM did not turn at top");
    a_match_flag: assert property (matchA |=> chanStatA.compareFlag)
        else $error("compare flag not raised on match");
    a_flag_clear: assert property ((chanCfgA.flagClear && !timerTick) |=> !chanStatA.compareFlag)
        else $error("compare flag not cleared");
    a_ovf_sticky: assert property ((overflowFlag && !overflowFlagClear) |=> overflowFlag)
        else $error("overflow flag dropped by itself");
    a_tick_full: assert property (clockSelect == 3'h1 |-> timerTick)
        else $error("undivided tick missing");
    a_pin_drive: assert property (chanStatA.pinOeN == !chanCfgA.pinDirOut)
        else $error("pin enable does not follow direction");
    a_idle_output: assert property (chanCfgA.outputActionSelect == TMW_ACT_NONE
        |=> $stable(chanStatA.compareOutput)) else $error("output moved with no action");

    c_ctc_match: cover property (waveformModeSelect == TMW_MODE_CTC && matchA && countValue != 8'h00);
    c_fast_top: cover property (waveformModeSelect == TMW_MODE_FAST && plainTick && countValue == TMW_MAX);
    c_phase_top: cover property (waveformModeSelect == TMW_MODE_PC_MAX && plainTick && countValue == TMW_MAX);
endmodule // tmw_timer8_waveform_checker

bind tmw_timer8_waveform tmw_timer8_waveform_checker u_checker (
    .core_clk(core_clk), .rst(rst), .clockSelect(clockSelect), .waveformModeSelect(waveformModeSelect),
    .countWrite(countWrite), .overflowFlagClear(overflowFlagClear), .chanCfgA(chanCfgA),
    .countValue(countValue), .overflowFlag(overflowFlag), .timerTick(timerTick), .chanStatA(chanStatA));

`default_nettype wire

// ---- tb_tmw_timer8_waveform.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_tmw_timer8_waveform import tmw_pkg::*;;
    typedef struct {int sel; logic [7:0] v;} tmw_note_t;
    logic           core_clk, rst, countWrite, overflowFlagClear, overflowFlag, timerTick;
    logic [2:0]     clockSelect, waveformModeSelect;
    logic [7:0]     countWriteData, countValue, seen, rnd;
    tmw_chan_cfg_t  chanCfgA, chanCfgB;
    tmw_chan_stat_t chanStatA, chanStatB;
    wire logic      pinLevelA, pinLevelB;
    tmw_note_t      noteQ[$];
    tmw_note_t      cur;
    int             fail_count, checks_done, seed;
    int             divTab[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

    tmw_timer8_waveform DUT (.core_clk(core_clk), .rst(rst), .clockSelect(clockSelect),
        .waveformModeSelect(waveformModeSelect), .countWrite(countWrite), .countWriteData(countWriteData),
        .overflowFlagClear(overflowFlagClear), .chanCfgA(chanCfgA), .chanCfgB(chanCfgB), .countValue(countValue),
        .overflowFlag(overflowFlag), .timerTick(timerTick), .chanStatA(chanStatA), .chanStatB(chanStatB));
    tmw_pin_load u_loadA (.pinOut(chanStatA.pinOut), .pinOeN(chanStatA.pinOeN), .pinLevel(pinLevelA));
    tmw_pin_load u_loadB (.pinOut(chanStatB.pinOut), .pinOeN(chanStatB.pinOeN), .pinLevel(pinLevelB));

    // ----------------------------
    // Tasks
    // ----------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic note(input int sel, input logic [7:0] v);
        noteQ.push_back('{sel, v});
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic loadCount(input logic [7:0] v);
        countWrite = 1'b1;
        countWriteData = v;
        tk(1);
        countWrite = 1'b0;
    endtask
    task automatic clrFlags();
        overflowFlagClear = 1'b1;
        chanCfgA.flagClear = 1'b1;
        tk(1);
        overflowFlagClear = 1'b0;
        chanCfgA.flagClear = 1'b0;
    endtask
    task automatic writeCmp(input logic [7:0] a, input logic [7:0] b);
        chanCfgA.compareData = a;
        chanCfgB.compareData = b;
        chanCfgA.compareWrite = 1'b1;
        chanCfgB.compareWrite = 1'b1;
        tk(1);
        chanCfgA.compareWrite = 1'b0;
        chanCfgB.compareWrite = 1'b0;
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Scoreboard settles one step after the driver's falling edge
    always @(negedge core_clk) begin
        #1;
        while (noteQ.size() > 0) begin
            cur = noteQ.pop_front();
            case (cur.sel)
                0: seen = countValue;
                1: seen = {7'h00, overflowFlag};
                2: seen = {7'h00, chanStatA.compareOutput};
                3: seen = {7'h00, chanStatA.compareFlag};
                4: seen = {7'h00, chanStatB.compareOutput};
                5: seen = chanStatA.compareActive;
                6: seen = {7'h00, pinLevelA};
                8: seen = {7'h00, chanStatB.compareFlag};
                9: seen = chanStatB.compareActive;
                default: seen = {7'h00, pinLevelB};
            endcase
            check(seen, cur.v);
        end
    end

    initial begin
        repeat (9000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        seed = 32'hD4E78E59;
        {rst, clockSelect, waveformModeSelect} = {1'b1, 3'h1, TMW_MODE_NORMAL};
        {countWrite, countWriteData, overflowFlagClear} = '0;
        {chanCfgA, chanCfgB} = '0;
        {fail_count, checks_done} = '0;
        tk(16);
        rst = 1'b0;
        note(0, 8'h00);
        note(1, 8'h00);
        rnd = 8'($random(seed));
        chanCfgA.pinDirOut = 1'b1;
        chanCfgB.pinDirOut = rnd[0];
        chanCfgB.portData = rnd[1];
        loadCount(8'hFD);
        clrFlags();
        tk(2);
        note(0, 8'h00);
        note(1, 8'h01);
        note(2, 8'h00);
        note(7, {7'h00, rnd[1] | !rnd[0]});
        rnd = 8'($random(seed));
        loadCount({1'b0, rnd[6:0]});
        tk(9);
        note(0, {1'b0, rnd[6:0]} + 8'h09);
        for (int i = 2; i < 8; i++) begin
            clockSelect = 3'(i);
            loadCount(8'h10);
            tk(2 * divTab[i]);
            note(0, 8'h12);
        end
        {clockSelect, waveformModeSelect} = {TMW_CS_STOP, TMW_MODE_CTC};
        chanCfgA.outputActionSelect = TMW_ACT_TOGGLE;
        chanCfgA.portData = 1'b1;
        writeCmp(8'h05, 8'h00);
        loadCount(8'h10);
        clrFlags();
        chanCfgA.forceCompareStrobe = 1'b1;
        tk(1);
        chanCfgA.forceCompareStrobe = 1'b0;
        note(2, 8'h01);
        note(3, 8'h00);
        note(0, 8'h10);
        note(5, 8'h05);
        clockSelect = 3'h1;
        tk(240);
        note(0, 8'h00);
        note(1, 8'h01);
        note(3, 8'h00);
        tk(5);
        note(0, 8'h05);
        tk(1);
        note(0, 8'h00);
        note(3, 8'h01);
        note(2, 8'h00);
        note(6, 8'h00);
        note(8, 8'h01);
        clockSelect = TMW_CS_STOP;
        loadCount(8'h05);
        clrFlags();
        clockSelect = 3'h1;
        tk(1);
        note(0, 8'h06);
        note(3, 8'h00);
        note(2, 8'h00);
        {clockSelect, waveformModeSelect} = {TMW_CS_STOP, TMW_MODE_FAST};
        chanCfgA.outputActionSelect = TMW_ACT_CLEAR;
        chanCfgB.outputActionSelect = TMW_ACT_SET;
        writeCmp(8'h40, 8'h40);
        loadCount(8'hFE);
        clrFlags();
        note(5, 8'h05);
        clockSelect = 3'h1;
        tk(2);
        note(0, 8'h00);
        note(1, 8'h01);
        note(2, 8'h01);
        note(4, 8'h00);
        note(5, 8'h40);
        note(9, 8'h40);
        tk(65);
        note(2, 8'h00);
        note(4, 8'h01);
        {clockSelect, waveformModeSelect} = {TMW_CS_STOP, TMW_MODE_PC_MAX};
        writeCmp(8'hF0, 8'h40);
        loadCount(8'hFD);
        clrFlags();
        clockSelect = 3'h1;
        tk(3);
        note(0, 8'hFE);
        note(5, 8'hF0);
        tk(14);
        note(0, 8'hF0);
        note(2, 8'h00);
        tk(1);
        note(2, 8'h01);
        tk(239);
        note(0, 8'h00);
        note(1, 8'h01);
        tk(2);
        {clockSelect, waveformModeSelect} = {TMW_CS_STOP, TMW_MODE_FAST_A};
        chanCfgA.outputActionSelect = TMW_ACT_TOGGLE;
        writeCmp(8'h03, 8'h01);
        loadCount(8'hEF);
        clockSelect = 3'h1;
        tk(2);
        note(0, 8'h00);
        note(2, 8'h00);
        note(5, 8'h03);
        tk(4);
        note(0, 8'h00);
        note(2, 8'h01);
        wrap_up();
    end
endmodule // tb_tmw_timer8_waveform

`default_nettype wire
